// ---- core/dp_timing_pkg.sv ----
// constants for the data-port timing control register bank
// assumes byte-wide registers behind a 3-wire serial configuration port
package dp_timing_pkg;
    // register offsets
    localparam logic [6:0] ADDR_IRQ_ROUTE_SELECT_HI   = 7'h08;
    localparam logic [6:0] ADDR_FRAME_PIN_CONFIG      = 7'h09;
    localparam logic [6:0] ADDR_DATA_RECEIVER_CTRL_A  = 7'h0a;
    localparam logic [6:0] ADDR_DATA_RECEIVER_CTRL_B  = 7'h0b;
    localparam logic [6:0] ADDR_DATA_RECEIVER_CTRL_C  = 7'h0c;
    localparam logic [6:0] ADDR_DATA_RECEIVER_CTRL_D  = 7'h0d;
    localparam logic [6:0] ADDR_DATA_RECEIVER_STATUS  = 7'h0e;
    localparam logic [6:0] ADDR_CONV_CLOCK_INPUT_CTRL = 7'h10;
    // reset values
    localparam logic [7:0] RST_IRQ_ROUTE_SELECT_HI    = 8'h00;
    localparam logic [7:0] RST_FRAME_PIN_CONFIG       = 8'h00;
    localparam logic [7:0] RST_DATA_RECEIVER_CTRL_A   = 8'h40;
    localparam logic [7:0] RST_DATA_RECEIVER_CTRL_B   = 8'h39;
    localparam logic [7:0] RST_DATA_RECEIVER_CTRL_C   = 8'h64;
    localparam logic [7:0] RST_DATA_RECEIVER_CTRL_D   = 8'h06;
    localparam logic [7:0] RST_CONV_CLOCK_INPUT_CTRL  = 8'hff;
    // implemented route selector bits (bit 3 has no source)
    localparam logic [7:0] ROUTE_MASK                 = 8'hf7;
    // field positions
    localparam int         POS_PARITY_IN_USE          = 5;
    localparam int         POS_FRAMING_IN_USE         = 4;
    localparam int         POS_LOOP_ENABLE            = 7;
    localparam int         POS_DATA_CLOCK_DUTY        = 6;
    localparam int         POS_CLEAR_WARN             = 7;
    localparam int         POS_SLOW_DATA_CLOCK        = 7;
    localparam int         POS_FIXED_DELAY_LINE       = 4;
    localparam int         POS_CONV_DUTY_FIX          = 7;
    localparam int         POS_CONV_CROSS_CTRL_ON     = 5;
    localparam int         POS_WARN_SOURCE            = 5;
    // serial frame: 8 instruction bits then 8 data bits
    localparam logic [4:0] SER_INSTR_LAST             = 5'd7;
    localparam logic [4:0] SER_DATA_LAST              = 5'd15;
    localparam logic [4:0] SER_FRAME_BITS             = 5'd16;
    localparam logic [2:0] PHASE_MAG_MAX              = 3'd6;
endpackage : dp_timing_pkg

// ---- core/data_port_timing_ctrl_regs.sv ----
// control and status registers of the parallel data-input receiver
// assumes the serial port clock runs at most sys_clk/8; loop status comes from analog
// What this block does
// - each interrupt source routes to pin b when its selector is 1, else pin a
// - control a bit 6 turns data clock duty correction on, resets to 1
// - sign-magnitude phase offset, applied value limited to -6..+6
// - writing clear-warn 1 clears the three loop warning status bits
// - status bit 6 near either end, bit 5 at start, bit 4 at end
// - status bit 2 reads 1 while a data clock is detected
// - status bit 0 reads 1 while the closed loop is trying to lock
// - converter clock duty correction enable at bit 7, resets to 1
// - converter clock crosspoint control enable at bit 5, resets to 1
// - five-bit two's complement crosspoint level, resets to 0x1f
// - loop warning raises its interrupt source, gated by its enable
`timescale 1ns/10ps
module data_port_timing_ctrl_regs
    import dp_timing_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // serial configuration port pins
    input  wire logic        serialCs_n,
    input  wire logic        serialClk,
    input  wire logic        serialDataIn,
    output logic             serialDataOut,
    output logic             serialDataOe,
    // loop and detector status from the analog receiver
    input  wire logic        loopLocked,
    input  wire logic        loopAtStart,
    input  wire logic        loopAtEnd,
    input  wire logic        dataClockPresent,
    // interrupt flags and enables held by the neighbouring interrupt registers
    input  wire logic [7:0]  intFlags,
    input  wire logic [7:0]  intEnables,
    output logic             interruptPinA_n,
    output logic             interruptPinB_n,
    // controls to the receiver and clock input circuits
    output logic [1:0]       sharedPinFunction,
    output logic             parityInUse,
    output logic             framingInUse,
    output logic             loopEnable,
    output logic             dataClockDutyFix,
    output logic [3:0]       loopPhaseOffset,
    output logic             slowDataClockMode,
    output logic             fixedDelayLineMode,
    output logic             loopTracking,
    output logic             convClockDutyFix,
    output logic             convClockCrossCtrlOn,
    output logic [4:0]       convClockCrossLevel
);

    typedef struct packed {
        logic [1:0] csSync;
        logic [2:0] sclkSync;
        logic [1:0] sdiSync;
        logic [1:0] lockSync;
        logic [1:0] startSync;
        logic [1:0] endSync;
        logic [1:0] presentSync;
        logic [4:0] bitCount;
        logic [7:0] shift;
        logic       isRead;
        logic [6:0] addr;
        logic       sdoOut;
        logic       sdoEn;
        logic [7:0] routeSel;
        logic [7:0] frameCfg;
        logic [7:0] ctrlA;
        logic [7:0] ctrlB;
        logic [7:0] ctrlC;
        logic [7:0] ctrlD;
        logic [7:0] convClk;
        logic [3:0] phaseApplied;
        logic       startWarn;
        logic       endWarn;
        logic       pinA_n;
        logic       pinB_n;
    } state_t;

    state_t s_q;
    state_t s_d;

    // out-of-range magnitudes would walk the loop off its valid phases
    function automatic logic [3:0] clampPhase(input logic [7:0] wr);
        logic [2:0] mag;
        mag = wr[2:0];
        if (mag > PHASE_MAG_MAX)
        begin
            mag = PHASE_MAG_MAX;
        end
        return {wr[3], mag};
    endfunction : clampPhase

    // status byte assembled from live state
    function automatic logic [7:0] statusByte(input state_t s);
        logic running;
        running = s.ctrlA[POS_LOOP_ENABLE] & ~s.ctrlD[POS_FIXED_DELAY_LINE];
        return {s.lockSync[1] & s.ctrlA[POS_LOOP_ENABLE],
                s.startWarn | s.endWarn,
                s.startWarn,
                s.endWarn,
                1'b0,
                s.presentSync[1],
                1'b0,
                running};
    endfunction : statusByte

    // read multiplexer; unmapped offsets read zero
    function automatic logic [7:0] readReg(input state_t s, input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_IRQ_ROUTE_SELECT_HI:   v = s.routeSel;
            ADDR_FRAME_PIN_CONFIG:      v = s.frameCfg;
            ADDR_DATA_RECEIVER_CTRL_A:  v = s.ctrlA;
            ADDR_DATA_RECEIVER_CTRL_B:  v = s.ctrlB;
            ADDR_DATA_RECEIVER_CTRL_C:  v = s.ctrlC;
            ADDR_DATA_RECEIVER_CTRL_D:  v = s.ctrlD;
            ADDR_DATA_RECEIVER_STATUS:  v = statusByte(s);
            ADDR_CONV_CLOCK_INPUT_CTRL: v = s.convClk;
            default:                    v = 8'h00;
        endcase
        return v;
    endfunction : readReg

    // next state: synchronisers, serial engine, register writes, warnings, pins
    always_comb
    begin
        logic       sclkRise;
        logic       sclkFall;
        logic       doWrite;
        logic       clearWarn;
        logic [7:0] shifted;
        logic [7:0] active;
        sclkRise  = 1'b0;
        sclkFall  = 1'b0;
        doWrite   = 1'b0;
        clearWarn = 1'b0;
        shifted   = 8'h00;
        active    = 8'h00;
        s_d       = s_q;

        // two flops on every pin before anything reads it
        s_d.csSync      = {s_q.csSync[0], serialCs_n};
        s_d.sclkSync    = {s_q.sclkSync[1:0], serialClk};
        s_d.sdiSync     = {s_q.sdiSync[0], serialDataIn};
        s_d.lockSync    = {s_q.lockSync[0], loopLocked};
        s_d.startSync   = {s_q.startSync[0], loopAtStart};
        s_d.endSync     = {s_q.endSync[0], loopAtEnd};
        s_d.presentSync = {s_q.presentSync[0], dataClockPresent};

        sclkRise = s_q.sclkSync[1] & ~s_q.sclkSync[2];
        sclkFall = ~s_q.sclkSync[1] & s_q.sclkSync[2];
        shifted  = {s_q.shift[6:0], s_q.sdiSync[1]};

        if (s_q.csSync[1])
        begin
            // idle: frame aborted or finished, release the data pin
            s_d.bitCount = 5'd0;
            s_d.sdoEn    = 1'b0;
        end
        else if (sclkRise && s_q.bitCount < SER_FRAME_BITS)
        begin
            s_d.shift    = shifted;
            s_d.bitCount = s_q.bitCount + 5'd1;
            if (s_q.bitCount == SER_INSTR_LAST)
            begin
                s_d.isRead = shifted[7];
                s_d.addr   = shifted[6:0];
                if (shifted[7])
                begin
                    s_d.shift = readReg(s_q, shifted[6:0]);
                end
            end
            else if (s_q.bitCount == SER_DATA_LAST && !s_q.isRead)
            begin
                doWrite = 1'b1;
            end
        end
        else if (sclkFall && s_q.isRead && s_q.bitCount > SER_INSTR_LAST
                 && s_q.bitCount < SER_FRAME_BITS)
        begin
            s_d.sdoOut = s_q.shift[7];                        // msb first
            s_d.sdoEn  = 1'b1;
        end

        // register writes land on the same clock edge that shifts in the last data bit
        if (doWrite)
        begin
            case (s_q.addr)
                ADDR_IRQ_ROUTE_SELECT_HI:   s_d.routeSel = shifted & ROUTE_MASK;
                ADDR_FRAME_PIN_CONFIG:      s_d.frameCfg = shifted;
                ADDR_DATA_RECEIVER_CTRL_A:
                begin
                    s_d.ctrlA        = shifted;
                    s_d.phaseApplied = clampPhase(shifted);
                end
                ADDR_DATA_RECEIVER_CTRL_B:
                begin
                    s_d.ctrlB = shifted;
                    clearWarn = shifted[POS_CLEAR_WARN];
                end
                ADDR_DATA_RECEIVER_CTRL_C:  s_d.ctrlC    = shifted;
                ADDR_DATA_RECEIVER_CTRL_D:  s_d.ctrlD    = shifted;
                ADDR_CONV_CLOCK_INPUT_CTRL: s_d.convClk  = shifted;
                default:                    s_d.ctrlC    = s_q.ctrlC;
            endcase
        end

        // sticky warnings; a new warning in the clearing cycle survives
        s_d.startWarn = (s_q.startWarn & ~clearWarn) | s_q.startSync[1];
        s_d.endWarn   = (s_q.endWarn & ~clearWarn) | s_q.endSync[1];

        // loop warning joins the external flags, then enable and route
        active = intFlags;
        active[POS_WARN_SOURCE] = intFlags[POS_WARN_SOURCE] | s_q.startWarn
                                  | s_q.endWarn;
        active = active & intEnables & ROUTE_MASK;
        s_d.pinB_n = ~|(active & s_q.routeSel);
        s_d.pinA_n = ~|(active & ~s_q.routeSel);
    end

    // single state register; constants only under reset
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q              <= '0;
            s_q.csSync       <= 2'h3;
            s_q.routeSel     <= RST_IRQ_ROUTE_SELECT_HI;
            s_q.frameCfg     <= RST_FRAME_PIN_CONFIG;
            s_q.ctrlA        <= RST_DATA_RECEIVER_CTRL_A;
            s_q.ctrlB        <= RST_DATA_RECEIVER_CTRL_B;
            s_q.ctrlC        <= RST_DATA_RECEIVER_CTRL_C;
            s_q.ctrlD        <= RST_DATA_RECEIVER_CTRL_D;
            s_q.convClk      <= RST_CONV_CLOCK_INPUT_CTRL;
            s_q.pinA_n       <= 1'b1;
            s_q.pinB_n       <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // outputs straight from state flops, except loopTracking, which gates two of them
    assign serialDataOut        = s_q.sdoOut;
    assign serialDataOe         = s_q.sdoEn;
    assign interruptPinA_n      = s_q.pinA_n;
    assign interruptPinB_n      = s_q.pinB_n;
    assign sharedPinFunction    = s_q.frameCfg[1:0];
    assign parityInUse          = s_q.frameCfg[POS_PARITY_IN_USE];
    assign framingInUse         = s_q.frameCfg[POS_FRAMING_IN_USE];
    assign loopEnable           = s_q.ctrlA[POS_LOOP_ENABLE];
    assign dataClockDutyFix     = s_q.ctrlA[POS_DATA_CLOCK_DUTY];
    assign loopPhaseOffset      = s_q.phaseApplied;
    assign slowDataClockMode    = s_q.ctrlD[POS_SLOW_DATA_CLOCK];
    assign fixedDelayLineMode   = s_q.ctrlD[POS_FIXED_DELAY_LINE];
    assign loopTracking         = s_q.ctrlA[POS_LOOP_ENABLE]
                                  & ~s_q.ctrlD[POS_FIXED_DELAY_LINE];
    assign convClockDutyFix     = s_q.convClk[POS_CONV_DUTY_FIX];
    assign convClockCrossCtrlOn = s_q.convClk[POS_CONV_CROSS_CTRL_ON];
    assign convClockCrossLevel  = s_q.convClk[4:0];

endmodule : data_port_timing_ctrl_regs

// ---- verification/dp_timing_assertions.sv ----
// port-level checks for the data-port timing control register bank
// assumes it is bound into data_port_timing_ctrl_regs and sees only its ports
`timescale 1ns/10ps
module dp_timing_assertions
    import dp_timing_pkg::*;
(
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       resetn,
    // serial port and interrupts
    input wire logic       serialCs_n,
    input wire logic       serialDataOe,
    input wire logic [7:0] intFlags,
    input wire logic [7:0] intEnables,
    input wire logic       interruptPinA_n,
    input wire logic       interruptPinB_n,
    // register fields
    input wire logic [1:0] sharedPinFunction,
    input wire logic       loopEnable,
    input wire logic       dataClockDutyFix,
    input wire logic [3:0] loopPhaseOffset,
    input wire logic       fixedDelayLineMode,
    input wire logic       loopTracking,
    input wire logic       convClockDutyFix,
    input wire logic       convClockCrossCtrlOn,
    input wire logic [4:0] convClockCrossLevel
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // enabled flags must reach some pin, bit 3 has no source
    AST_PIN_ACTIVE: assert property (
        |($past(intFlags & intEnables) & 8'hf7) |-> !(interruptPinA_n && interruptPinB_n))
        else $error("enabled flag reached no pin");
    // nothing enabled means both pins idle high
    AST_PIN_QUIET: assert property (
        $past((intEnables & 8'hf7) == 8'h00) |-> interruptPinA_n && interruptPinB_n)
        else $error("pin low with no source enabled");
    // applied phase magnitude never beyond six steps
    AST_PHASE_CLAMP: assert property (
        loopPhaseOffset[2:0] <= 3'd6)
        else $error("phase magnitude above six");
    // tracking follows loop enable and delay line mode
    AST_TRACKING: assert property (
        $stable(loopEnable) && $stable(fixedDelayLineMode)
        |-> loopTracking == (loopEnable && !fixedDelayLineMode))
        else $error("tracking status disagrees with controls");
    // data pin released once the port is deselected
    AST_OE_RELEASE: assert property (
        serialCs_n [*6] |-> !serialDataOe)
        else $error("data pin driven while deselected");
    // fields change only through a frame
    AST_FIELDS_HOLD: assert property (
        serialCs_n [*8] |-> $stable({sharedPinFunction, loopEnable, loopPhaseOffset,
                                     convClockCrossLevel}))
        else $error("field changed outside a frame");
    // converter clock controls leave reset switched on
    AST_CONV_RESET: assert property (
        $rose(resetn) |-> convClockDutyFix && convClockCrossCtrlOn
                          && convClockCrossLevel == 5'h1f)
        else $error("converter clock reset value wrong");
    // data duty fix on, loop off, pins idle after reset
    AST_DATA_RESET: assert property (
        $rose(resetn) |-> dataClockDutyFix && !loopEnable && interruptPinA_n
                          && interruptPinB_n && !serialDataOe)
        else $error("data receiver reset value wrong");
endmodule : dp_timing_assertions

bind data_port_timing_ctrl_regs dp_timing_assertions i_dp_timing_assertions (
    .sys_clk              (sys_clk),
    .resetn               (resetn),
    .serialCs_n           (serialCs_n),
    .serialDataOe         (serialDataOe),
    .intFlags             (intFlags),
    .intEnables           (intEnables),
    .interruptPinA_n      (interruptPinA_n),
    .interruptPinB_n      (interruptPinB_n),
    .sharedPinFunction    (sharedPinFunction),
    .loopEnable           (loopEnable),
    .dataClockDutyFix     (dataClockDutyFix),
    .loopPhaseOffset      (loopPhaseOffset),
    .fixedDelayLineMode   (fixedDelayLineMode),
    .loopTracking         (loopTracking),
    .convClockDutyFix     (convClockDutyFix),
    .convClockCrossCtrlOn (convClockCrossCtrlOn),
    .convClockCrossLevel  (convClockCrossLevel)
);

// ---- verification/data_port_timing_ctrl_regs_test.sv ----
// self-checking bench for the data-port timing control register bank
// assumes the bench plays host on the serial port and the analog status inputs
`timescale 1ns/10ps
module data_port_timing_ctrl_regs_test;
    import dp_timing_pkg::*;
    logic       sys_clk = 0, resetn = 0, serialCs_n = 1, serialClk = 0, benchData = 0;
    logic       loopLocked = 0, loopAtStart = 0, loopAtEnd = 0, dataClockPresent = 0;
    logic [7:0] intFlags = 8'h00, intEnables = 8'h00;
    wire logic  serialDataIn;
    logic       serialDataOut, serialDataOe, interruptPinA_n, interruptPinB_n;
    logic [1:0] sharedPinFunction;
    logic [3:0] loopPhaseOffset;
    logic [4:0] convClockCrossLevel;
    logic       parityInUse, framingInUse, loopEnable, dataClockDutyFix, slowDataClockMode;
    logic       fixedDelayLineMode, loopTracking, convClockDutyFix, convClockCrossCtrlOn;
    int         mismatches = 0, checksDone = 0;
    logic [6:0] ra [8] = '{7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h10};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h40, 8'h39, 8'h64, 8'h06, 8'h00, 8'hff};

    // shared data pin: device wins while it drives
    assign serialDataIn = serialDataOe ? serialDataOut : benchData;
    always #4 sys_clk = ~sys_clk;

    data_port_timing_ctrl_regs i_data_port_timing_ctrl_regs (
        .sys_clk              (sys_clk),
        .resetn               (resetn),
        .serialCs_n           (serialCs_n),
        .serialClk            (serialClk),
        .serialDataIn         (serialDataIn),
        .serialDataOut        (serialDataOut),
        .serialDataOe         (serialDataOe),
        .loopLocked           (loopLocked),
        .loopAtStart          (loopAtStart),
        .loopAtEnd            (loopAtEnd),
        .dataClockPresent     (dataClockPresent),
        .intFlags             (intFlags),
        .intEnables           (intEnables),
        .interruptPinA_n      (interruptPinA_n),
        .interruptPinB_n      (interruptPinB_n),
        .sharedPinFunction    (sharedPinFunction),
        .parityInUse          (parityInUse),
        .framingInUse         (framingInUse),
        .loopEnable           (loopEnable),
        .dataClockDutyFix     (dataClockDutyFix),
        .loopPhaseOffset      (loopPhaseOffset),
        .slowDataClockMode    (slowDataClockMode),
        .fixedDelayLineMode   (fixedDelayLineMode),
        .loopTracking         (loopTracking),
        .convClockDutyFix     (convClockDutyFix),
        .convClockCrossCtrlOn (convClockCrossCtrlOn),
        .convClockCrossLevel  (convClockCrossLevel)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one frame; half periods of 5 clocks keep within the sys_clk/8 limit
    task automatic ser(input logic rw, input logic [6:0] a, input logic [7:0] wd,
                       output logic [7:0] rd);
        logic [15:0] f;
        f = {rw, a, wd};
        rd = 8'h00;
        serialCs_n = 0;
        repeat (5) @(negedge sys_clk);
        for (int i = 15; i >= 0; i--)
        begin
            benchData = f[i];
            repeat (5) @(negedge sys_clk);
            serialClk = 1;
            if (i < 8)
                rd[i] = serialDataIn;
            repeat (5) @(negedge sys_clk);
            serialClk = 0;
        end
        repeat (5) @(negedge sys_clk);
        serialCs_n = 1;
        benchData = ~benchData;
        repeat (8) @(negedge sys_clk);
    endtask : ser

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        ser(1'b0, a, d, unused);
    endtask : wr

    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] got;
        ser(1'b1, a, 8'h00, got);
        chk(got, exp);
    endtask : rdc

    task automatic pulse(ref logic s);
        s = 1;
        repeat (10) @(negedge sys_clk);
        s = 0;
    endtask : pulse

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    // watchdog: the sequence needs roughly 45 us
    initial
    begin
        #400000;
        mismatches++;
        complete_run;
    end

    // main sequence
    initial
    begin
        repeat (20) @(negedge sys_clk);
        resetn = 1;
        // chip select waits out the synchroniser after reset
        repeat (3) @(negedge sys_clk);
        for (int k = 0; k < 8; k++)
            rdc(ra[k], rv[k]);
        $display("test reset values done");
        wr(7'h0a, 8'h8e);
        chk(8'({loopEnable, dataClockDutyFix, loopPhaseOffset}), 8'h2e);
        wr(7'h0a, 8'h0f);
        chk(8'(loopPhaseOffset), 8'h0e);
        rdc(7'h0a, 8'h0f);
        wr(7'h0d, 8'h96);
        chk(8'({slowDataClockMode, fixedDelayLineMode, loopTracking}), 8'h06);
        wr(7'h0a, 8'h80);
        wr(7'h0d, 8'h06);
        chk(8'(loopTracking), 8'h01);
        $display("test loop controls done");
        // code 3 is reserved, so software never writes it
        for (int k = 0; k < 3; k++)
        begin
            wr(7'h09, {2'b00, k == 1, k == 2, 2'b00, k[1:0]});
            chk(8'({sharedPinFunction, parityInUse, framingInUse}),
                8'({k[1:0], k == 1, k == 2}));
        end
        $display("test frame pin done");
        loopLocked = 1;
        dataClockPresent = 1;
        pulse(loopAtStart);
        rdc(7'h0e, 8'he5);
        wr(7'h0b, 8'hb9);
        rdc(7'h0e, 8'h85);
        wr(7'h0e, 8'hff);
        rdc(7'h0e, 8'h85);
        pulse(loopAtEnd);
        rdc(7'h0e, 8'hd5);
        $display("test status done");
        intEnables = 8'h20;
        repeat (3) @(negedge sys_clk);
        chk(8'({interruptPinA_n, interruptPinB_n}), 8'h01);
        wr(7'h08, 8'hff);
        chk(8'({interruptPinA_n, interruptPinB_n}), 8'h02);
        rdc(7'h08, 8'hf7);
        wr(7'h0b, 8'hb9);
        chk(8'({interruptPinA_n, interruptPinB_n}), 8'h03);
        intEnables = 8'hff;
        intFlags = 8'h08;
        repeat (3) @(negedge sys_clk);
        chk(8'({interruptPinA_n, interruptPinB_n}), 8'h03);
        intFlags = 8'h40;
        repeat (3) @(negedge sys_clk);
        chk(8'({interruptPinA_n, interruptPinB_n}), 8'h02);
        wr(7'h08, 8'h00);
        chk(8'({interruptPinA_n, interruptPinB_n}), 8'h01);
        $display("test interrupt routing done");
        wr(7'h7f, 8'h00);
        rdc(7'h10, 8'hff);
        wr(7'h10, 8'h4f);
        chk(8'({convClockDutyFix, convClockCrossCtrlOn, convClockCrossLevel}), 8'h0f);
        rdc(7'h10, 8'h4f);
        $display("test converter clock done");
        complete_run;
    end
endmodule : data_port_timing_ctrl_regs_test
